// ---- tho_pkg.sv ----
package tho_pkg;
	localparam int ADDR_W = 18;
	localparam int ACC_W = 72;
	localparam int CNT_W = 24;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_FREE_LO = 16'h0300;
	localparam logic [15:0] IDX_FREE_HI = 16'h0301;
	localparam logic [15:0] IDX_INTERVAL = 16'h0318;
	localparam logic [15:0] IDX_HIST_MODE = 16'h031B;
	localparam logic [15:0] IDX_LOOP_MODE = 16'h0A01;
	localparam logic [15:0] IDX_LOOP_CMD = 16'h0A03;
	localparam logic [15:0] IDX_HIST_LO = 16'h0D14;
	localparam logic [15:0] IDX_HIST_HI = 16'h0D15;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h0D30;
	localparam logic [15:0] IDX_IRQ_STAT = 16'h0D31;
	localparam logic [15:0] IDX_PIN_CFG = 16'h0D32;
	localparam logic [15:0] IDX_STATUS = 16'h0D33;
	// Field positions
	localparam int HM_RETAIN = 3;
	localparam int HM_FALLBACK = 4;
	localparam int LM_USER_HOLD = 6;
	localparam int LM_USER_FREE = 5;
	localparam int LM_FORCE_REF = 4;
	localparam int LC_CLEAR_HIST = 2;
	localparam int PC_STROBE_OUT = 0;
	localparam int PC_CLEAR_IN = 1;
	localparam int IRQ_HIST = 0;
	// Reset values
	localparam logic [23:0] INTERVAL_RST = 24'h0003E8;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [47:0] WORD_RST = 48'h000000000000;
	// Millisecond tick
	localparam int MS_NS = 1000000;
	localparam int CLK_NS = 100;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam int DIV_STEPS = ACC_W;

	typedef enum logic [4:0] {
		ST_FREE = 5'b00001,
		ST_CLOSED = 5'b00010,
		ST_HOLD = 5'b00100,
		ST_SWITCH = 5'b01000,
		ST_RECOVER = 5'b10000
	} tho_state_e;
endpackage

// ---- tho_holdover_ctrl.sv ----
// How it works
// - Average loop filter words per interval into the 48-bit history register.
// - Each interval starts from an empty accumulator; no sliding average.
// - Pulse a strobe at each interval end; masked strobe sets history-updated flag.
// - Strobe can be routed to a multipurpose output pin.
// - Accumulation restarts whenever a new reference is taken.
// - Loop command bit 2 or a configured pin clears the history.
// - History is dropped on a reference switch unless the retain bit is set.
// - With no history, nothing is stored until the first point of the schedule.
// - After a clear, K gives averages at interval over 2^K, doubling up to full.
// - K of zero means only the full-interval average.
// - After the first interval, averages come one full interval apart.
// - State machine sequences switches and holdover, applying the reference profile.
// - Loop mode register forces holdover, free-run or a chosen reference.
// - A switchover is a brief holdover followed at once by recovery.
// - Lock indications are frozen during a switchover.
// - Holdover runs open loop on the latest stored history average.
// - No history and fallback clear: holdover uses the free-run word.
// - No history and fallback set: hold the last instantaneous word.
// - A valid reference in holdover brings recovery and profile restore.
// - User holdover bit keeps holdover despite a valid reference.
// - Interval is a 24-bit millisecond count; zero must not be programmed.
// - Free-run uses the free-run word, closed loop the loop filter word.
`timescale 1ns/10ps
module tho_holdover_ctrl #(
	parameter int MS_CYCLES = tho_pkg::MS_CYCLES
) (
	input wire logic mclk, // System sample clock
	input wire logic rst_b, // Async reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [tho_pkg::ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [47:0] loop_word, // Loop filter tuning word
	input wire logic [3:0] ref_valid, // Reference monitor valid flags
	input wire logic lock_in, // Lock detector indication
	input wire logic mpin_in, // Multipurpose pin input
	output logic mpin_out, // Multipurpose pin output
	output logic [47:0] frequency_step_word, // Word to the DDS
	output logic [1:0] active_ref, // Reference in use
	output logic loop_closed, // Loop running closed
	output logic profile_apply, // Load profile of active_ref
	output logic lock_out // Lock indication to software
);
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [47:0] free_word;
		logic [23:0] interval;
		logic [7:0] hist_mode;
		logic [7:0] loop_mode;
		logic [7:0] irq_mask;
		logic [7:0] irq_stat;
		logic [7:0] pin_cfg;
		logic pin_s1;
		logic pin_s2;
		logic pin_s3;
		logic pin_lvl;
		logic mpin_out;
		tho_pkg::tho_state_e state;
		logic [1:0] active_ref;
		logic [1:0] next_ref;
		logic profile_apply;
		logic lock_out;
		logic [47:0] dds_word;
		logic [47:0] hold_word;
		logic [15:0] ms_cnt;
		logic [tho_pkg::ACC_W-1:0] acc;
		logic [tho_pkg::CNT_W-1:0] cnt;
		logic first;
		logic [2:0] shift;
		logic loop_closed;
		logic tracking;
		logic [47:0] hist_word;
		logic hist_exists;
	} tho_regs_s;

	tho_regs_s q;
	tho_regs_s next_q;

	function automatic logic [1:0] tho_lowest(input logic [3:0] v);
		tho_lowest = 2'h0;
		for (int i = 3; i >= 0; i--)
		begin
			if (v[i])
				tho_lowest = 2'(i);
		end
	endfunction

	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	logic [15:0] idx;
	logic hit;
	logic [31:0] rd;
	logic wr;
	logic ms_tick;
	logic sw_clear;
	logic pin_clear;
	logic hist_clear;
	logic [1:0] want_ref;
	logic want_ok;
	logic [tho_pkg::ACC_W-1:0] acc_add;
	logic [tho_pkg::CNT_W-1:0] cnt_add;
	logic [tho_pkg::CNT_W-1:0] point;
	logic [tho_pkg::ACC_W-1:0] quot;
	logic restart;
	logic strobe;
	logic sample;
	logic [47:0] hold_pick;

	always_comb
	begin
		next_q = q;
		next_q.pready = 1'b0;
		next_q.pslverr = 1'b0;
		next_q.profile_apply = 1'b0;
		idx = 16'(paddr[tho_pkg::ADDR_W-1:2]);
		hit = (paddr[1:0] == 2'h0);
		rd = 32'h00000000;
		case (idx)
			tho_pkg::IDX_FREE_LO: rd = q.free_word[31:0];
			tho_pkg::IDX_FREE_HI: rd = {16'h0000, q.free_word[47:32]};
			tho_pkg::IDX_INTERVAL: rd = {8'h00, q.interval};
			tho_pkg::IDX_HIST_MODE: rd = {24'h000000, q.hist_mode};
			tho_pkg::IDX_LOOP_MODE: rd = {24'h000000, q.loop_mode};
			tho_pkg::IDX_LOOP_CMD: rd = 32'h00000000;
			tho_pkg::IDX_HIST_LO: rd = q.hist_word[31:0];
			tho_pkg::IDX_HIST_HI: rd = {16'h0000, q.hist_word[47:32]};
			tho_pkg::IDX_IRQ_MASK: rd = {24'h000000, q.irq_mask};
			tho_pkg::IDX_IRQ_STAT: rd = {24'h000000, q.irq_stat};
			tho_pkg::IDX_PIN_CFG: rd = {24'h000000, q.pin_cfg};
			tho_pkg::IDX_STATUS: rd = {23'h000000, q.active_ref, q.loop_closed,
				q.hist_exists, q.state};
			default: hit = 1'b0;
		endcase
		// No wait state; read data is registered in the setup phase so it leaves a flip-flop
		if (psel && !penable && !q.pready)
		begin
			next_q.pready = 1'b1;
			next_q.prdata = pwrite ? 32'h00000000 : rd;
			next_q.pslverr = !hit;
		end
		wr = psel && penable && q.pready && pwrite && hit;
		sw_clear = 1'b0;
		if (wr)
		begin
			case (idx)
				tho_pkg::IDX_FREE_LO: next_q.free_word[31:0] = pwdata;
				tho_pkg::IDX_FREE_HI: next_q.free_word[47:32] = pwdata[15:0];
				tho_pkg::IDX_INTERVAL: next_q.interval = pwdata[23:0];
				tho_pkg::IDX_HIST_MODE: next_q.hist_mode = pwdata[7:0];
				tho_pkg::IDX_LOOP_MODE: next_q.loop_mode = pwdata[7:0];
				tho_pkg::IDX_LOOP_CMD: sw_clear = pwdata[tho_pkg::LC_CLEAR_HIST];
				tho_pkg::IDX_IRQ_MASK: next_q.irq_mask = pwdata[7:0];
				tho_pkg::IDX_IRQ_STAT: next_q.irq_stat = q.irq_stat & ~pwdata[7:0];
				tho_pkg::IDX_PIN_CFG: next_q.pin_cfg = pwdata[7:0];
				default: sw_clear = 1'b0;
			endcase
		end

		// Pin filter: a change counts once stages two and three agree
		next_q.pin_s1 = mpin_in;
		next_q.pin_s2 = q.pin_s1;
		next_q.pin_s3 = q.pin_s2;
		if (q.pin_s2 == q.pin_s3)
			next_q.pin_lvl = q.pin_s3;
		pin_clear = q.pin_cfg[tho_pkg::PC_CLEAR_IN] && (q.pin_s2 == q.pin_s3)
			&& q.pin_s3 && !q.pin_lvl;

		// Reference choice and loop state machine
		want_ref = q.loop_mode[tho_pkg::LM_FORCE_REF] ? q.loop_mode[1:0]
			: tho_lowest(ref_valid);
		want_ok = ref_valid[want_ref];
		hold_pick = q.hist_exists ? q.hist_word
			: (q.hist_mode[tho_pkg::HM_FALLBACK] ? q.dds_word
			: q.free_word);
		hist_clear = sw_clear || pin_clear;
		restart = 1'b0;
		case (q.state)
			tho_pkg::ST_FREE:
			begin
				next_q.tracking = 1'b0;
				if (q.loop_mode[tho_pkg::LM_USER_FREE])
					next_q.state = tho_pkg::ST_FREE;
				else if (q.loop_mode[tho_pkg::LM_USER_HOLD])
				begin
					next_q.hold_word = hold_pick;
					next_q.state = tho_pkg::ST_HOLD;
				end
				else if (want_ok)
				begin
					next_q.next_ref = want_ref;
					next_q.state = tho_pkg::ST_RECOVER;
				end
			end
			tho_pkg::ST_CLOSED:
			begin
				if (q.loop_mode[tho_pkg::LM_USER_FREE])
					next_q.state = tho_pkg::ST_FREE;
				else if (q.loop_mode[tho_pkg::LM_USER_HOLD] || !want_ok)
				begin
					next_q.hold_word = hold_pick;
					next_q.state = tho_pkg::ST_HOLD;
				end
				else if (want_ref != q.active_ref)
				begin
					next_q.hold_word = hold_pick;
					next_q.next_ref = want_ref;
					next_q.state = tho_pkg::ST_SWITCH;
				end
			end
			tho_pkg::ST_HOLD:
			begin
				if (q.loop_mode[tho_pkg::LM_USER_FREE])
					next_q.state = tho_pkg::ST_FREE;
				else if (!q.loop_mode[tho_pkg::LM_USER_HOLD] && want_ok)
				begin
					next_q.next_ref = want_ref;
					next_q.state = tho_pkg::ST_RECOVER;
				end
			end
			tho_pkg::ST_SWITCH: next_q.state = tho_pkg::ST_RECOVER;
			tho_pkg::ST_RECOVER:
			begin
				next_q.profile_apply = 1'b1;
				next_q.active_ref = q.next_ref;
				next_q.state = tho_pkg::ST_CLOSED;
				next_q.tracking = 1'b1;
				if (!q.tracking || q.next_ref != q.active_ref)
				begin
					restart = 1'b1;
					if (!q.hist_mode[tho_pkg::HM_RETAIN])
						hist_clear = 1'b1;
				end
			end
			default: next_q.state = tho_pkg::ST_FREE;
		endcase

		// Millisecond timer; it only runs while the loop tracks a reference
		// so holdover and free-run time never count towards an interval
		ms_tick = 1'b0;
		sample = (q.state == tho_pkg::ST_CLOSED);
		if (sample)
		begin
			if (q.ms_cnt == MS_LAST)
			begin
				next_q.ms_cnt = 16'h0000;
				ms_tick = 1'b1;
			end
			else
			begin
				next_q.ms_cnt = q.ms_cnt + 16'h0001;
			end
		end

		// One sample per millisecond; 24 spare bits hold the longest interval
		acc_add = q.acc + {24'h000000, loop_word};
		cnt_add = q.cnt + 24'h000001;

		// Early points of the first interval lie at interval over 2^shift
		if (q.first)
		begin
			point = q.interval >> q.shift;
		end
		else
		begin
			point = q.interval;
		end

		// A full divider costs area; a serial one of DIV_STEPS cycles would keep pace at the default MS_CYCLES
		// with intermediate points that fall one millisecond apart
		quot = acc_add / {48'h000000000000, cnt_add};
		strobe = 1'b0;

		// Sum and count grow on every tick; an average is taken at each point
		if (ms_tick)
		begin
			next_q.acc = acc_add;
			next_q.cnt = cnt_add;
			// Large K on a short interval pushes early points onto consecutive ticks
			if (cnt_add >= point)
			begin
				next_q.hist_word = quot[47:0];
				next_q.hist_exists = 1'b1;
				strobe = 1'b1;
				if (q.first && q.shift != 3'h0)
				begin
					// Intermediate average: keep summing to the next doubling
					next_q.shift = q.shift - 3'h1;
				end
				else
				begin
					// Next interval starts empty, with no carried samples
					next_q.acc = '0;
					next_q.cnt = '0;
					next_q.first = 1'b0;
				end
			end
		end

		// Restart and clear override a sample taken in the same cycle;
		// the timer restarts too so the points stay aligned to the start
		if (restart || hist_clear)
		begin
			next_q.acc = '0;
			next_q.cnt = '0;
			next_q.ms_cnt = 16'h0000;
		end
		if (hist_clear)
		begin
			// No history until the schedule reaches its first point
			next_q.first = 1'b1;
			next_q.shift = q.hist_mode[2:0];
			next_q.hist_exists = 1'b0;
		end

		// Strobe to the pin when routed there
		next_q.mpin_out = strobe && q.pin_cfg[tho_pkg::PC_STROBE_OUT];

		// Status flag: a set in the cycle of a software clear wins
		if (strobe && q.irq_mask[tho_pkg::IRQ_HIST])
		begin
			next_q.irq_stat[tho_pkg::IRQ_HIST] = 1'b1;
		end

		// DDS word source follows the state being entered
		case (next_q.state)
			tho_pkg::ST_CLOSED: next_q.dds_word = loop_word;
			tho_pkg::ST_FREE: next_q.dds_word = q.free_word;
			tho_pkg::ST_HOLD: next_q.dds_word = next_q.hold_word;
			tho_pkg::ST_SWITCH: next_q.dds_word = next_q.hold_word;
			default: next_q.dds_word = q.dds_word;
		endcase
		next_q.loop_closed = (next_q.state == tho_pkg::ST_CLOSED);

		// Lock indication frozen across a switchover so no false unlock shows
		if (q.state == tho_pkg::ST_SWITCH || q.state == tho_pkg::ST_RECOVER
			|| next_q.state == tho_pkg::ST_SWITCH)
		begin
			next_q.lock_out = q.lock_out;
		end
		else
		begin
			next_q.lock_out = lock_in;
		end
	end

	// Reset leaves the loop in free-run with no history
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q <= '0;
			q.state <= tho_pkg::ST_FREE;
			q.interval <= tho_pkg::INTERVAL_RST;
			q.first <= 1'b1;
		end
		else
		begin
			q <= next_q;
		end
	end

	// Every output is a register bit
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign mpin_out = q.mpin_out;
	assign frequency_step_word = q.dds_word;
	assign active_ref = q.active_ref;
	assign loop_closed = q.loop_closed;
	assign profile_apply = q.profile_apply;
	assign lock_out = q.lock_out;
endmodule

// ---- tho_chk.sv ----
`timescale 1ns/10ps
module tho_chk (
	input wire logic mclk, // Clock
	input wire logic rst_b, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [47:0] loop_word, // Filter word
	input wire logic [3:0] ref_valid, // Valid flags
	input wire logic lock_out, // Lock shown
	input wire logic mpin_out, // Strobe pin
	input wire logic [47:0] frequency_step_word, // DDS word
	input wire logic [1:0] active_ref, // Reference
	input wire logic loop_closed, // Closed loop
	input wire logic profile_apply // Profile load
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	property p_strobe_pulse; mpin_out |=> !mpin_out; endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too wide");
	property p_closed_word; (loop_closed && $stable(loop_word))[*3] |-> frequency_step_word == loop_word; endproperty
	a_closed_word: assert property (p_closed_word) else $error("closed word wrong");
	// Writes excluded: free word may be reprogrammed
	property p_open_steady; (!loop_closed && !(psel && pwrite) && $stable(active_ref))[*4] |-> $stable(frequency_step_word); endproperty
	a_open_steady: assert property (p_open_steady) else $error("open word moved");
	property p_switch_lock; $changed(active_ref) |-> $stable(lock_out); endproperty
	a_switch_lock: assert property (p_switch_lock) else $error("lock moved at switch");
	property p_profile; $changed(active_ref) |-> ##[0:8] profile_apply; endproperty
	a_profile: assert property (p_profile) else $error("no profile load");
	property p_switch_recover; $changed(active_ref) |-> ##[0:64] loop_closed; endproperty
	a_switch_recover: assert property (p_switch_recover) else $error("no recovery");
	property p_slverr; pslverr |-> psel && penable && pready; endproperty
	a_slverr: assert property (p_slverr) else $error("stray error");
	property p_invalid_open; (!ref_valid[active_ref])[*8] |-> !loop_closed; endproperty
	a_invalid_open: assert property (p_invalid_open) else $error("closed on bad ref");
	c_strobe: cover property (mpin_out);
	c_switch: cover property ($changed(active_ref));
	c_hold: cover property (!loop_closed && ref_valid != 4'h0);
endmodule
bind tho_holdover_ctrl tho_chk i_tho_chk (.mclk, .rst_b, .psel, .penable, .pwrite, .pready,
	.pslverr, .loop_word, .ref_valid, .lock_out, .mpin_out, .frequency_step_word, .active_ref,
	.loop_closed, .profile_apply);

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
	logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic lock_in = 1'b1, mpin_in = 1'b0, pready, pslverr, er, mpin_out, loop_closed;
	logic profile_apply, lock_out;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic [47:0] loop_word = 48'h135787654321, frequency_step_word;
	logic [3:0] ref_valid = 4'h1;
	logic [1:0] active_ref;
	int miscompares = 0, n_checks = 0, n;
	localparam logic [47:0] FREE = 48'h000000ABCDEF;
	tho_holdover_ctrl #(.MS_CYCLES(10)) i_tho_holdover_ctrl (.mclk, .rst_b, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .loop_word, .ref_valid, .lock_in,
		.mpin_in, .mpin_out, .frequency_step_word, .active_ref, .loop_closed, .profile_apply,
		.lock_out);
	always #50 mclk = ~mclk;
	task automatic finish_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Leading edge keeps psel from being driven twice in one step
	task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_strobe;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (mpin_out !== 1'b1);
	endtask
	task automatic wait_lc(input logic v);
		n = 0;
		while (loop_closed !== v && n < 80)
		begin
			@(posedge mclk);
			n++;
		end
		@(posedge mclk);
		chk({47'h0, loop_closed}, {47'h0, v});
	endtask
	task automatic hold_chk(input logic [47:0] e);
		apb(1'b1, tho_pkg::IDX_LOOP_MODE, 32'h00000040);
		wait_lc(1'b0);
		chk(frequency_step_word, e);
		apb(1'b1, tho_pkg::IDX_LOOP_MODE, 32'h00000000);
		wait_lc(1'b1);
	endtask
	task automatic t_regs;
		apb(1'b0, tho_pkg::IDX_INTERVAL, 32'h0);
		chk({24'h0, rd[23:0]}, {24'h0, tho_pkg::INTERVAL_RST});
		apb(1'b0, tho_pkg::IDX_HIST_LO, 32'h0);
		chk({16'h0, rd}, {16'h0, tho_pkg::WORD_RST[31:0]});
		apb(1'b0, 16'h0123, 32'h0);
		chk({47'h0, er}, 48'h1);
	endtask
	task automatic t_average;
		apb(1'b1, tho_pkg::IDX_INTERVAL, 32'h4);
		apb(1'b1, tho_pkg::IDX_PIN_CFG, 32'h3);
		apb(1'b1, tho_pkg::IDX_IRQ_MASK, 32'h1);
		apb(1'b1, tho_pkg::IDX_LOOP_CMD, 32'h4);
		wait_strobe();
		loop_word <= 48'h24688ACE1357;
		wait_strobe();
		wait_strobe();
		chk(48'(n), 48'h28);
		apb(1'b0, tho_pkg::IDX_HIST_LO, 32'h0);
		chk({16'h0, rd}, 48'h00008ACE1357);
		apb(1'b0, tho_pkg::IDX_HIST_HI, 32'h0);
		chk({32'h0, rd[15:0]}, 48'h2468);
		apb(1'b0, tho_pkg::IDX_IRQ_STAT, 32'h0);
		chk({40'h0, rd[7:0]}, 48'h1);
		loop_word <= 48'h000000001111;
		hold_chk(48'h24688ACE1357);
	endtask
	task automatic t_free;
		apb(1'b1, tho_pkg::IDX_FREE_LO, 32'h00ABCDEF);
		apb(1'b1, tho_pkg::IDX_LOOP_CMD, 32'h4);
		hold_chk(FREE);
		apb(1'b1, tho_pkg::IDX_LOOP_MODE, 32'h20);
		wait_lc(1'b0);
		chk(frequency_step_word, FREE);
		apb(1'b1, tho_pkg::IDX_LOOP_MODE, 32'h0);
		wait_lc(1'b1);
	endtask
	task automatic t_pin;
		apb(1'b1, tho_pkg::IDX_HIST_MODE, 32'h10);
		loop_word <= 48'h000000002222;
		mpin_in <= 1'b1;
		// Held long enough for the pin filter to accept it
		repeat (3) @(posedge mclk);
		mpin_in <= 1'b0;
		hold_chk(48'h000000002222);
	endtask
	task automatic t_interm;
		apb(1'b1, tho_pkg::IDX_HIST_MODE, 32'h2);
		apb(1'b1, tho_pkg::IDX_LOOP_CMD, 32'h4);
		wait_strobe();
		wait_strobe();
		chk(48'(n), 48'h0A);
		wait_strobe();
		chk(48'(n), 48'h14);
		wait_strobe();
		chk(48'(n), 48'h28);
	endtask
	task automatic t_switch;
		apb(1'b1, tho_pkg::IDX_HIST_MODE, 32'h0);
		ref_valid <= 4'h2;
		lock_in <= 1'b0;
		n = 0;
		while (active_ref !== 2'h1 && n < 80)
		begin
			@(posedge mclk);
			n++;
		end
		chk({46'h0, active_ref}, 48'h1);
		lock_in <= 1'b1;
		hold_chk(FREE);
	endtask
	initial
	begin
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		t_regs();
		t_average();
		t_free();
		t_pin();
		t_interm();
		t_switch();
		finish_test();
	end
	initial
	begin
		#200000;
		miscompares++;
		finish_test();
	end
endmodule
